/* src/flp_params.svh */
// Offsets, field positions, command codes and mode values for flash lock
`ifndef FLP_PARAMS_SVH
`define FLP_PARAMS_SVH
// Register offsets (byte addresses, one 32-bit register every 4)
`define FLP_OFS_CMD 8'h00
`define FLP_OFS_SADDR 8'h04
`define FLP_OFS_STATUS 8'h08
`define FLP_OFS_ENTRY 8'h0C
`define FLP_OFS_PROT 8'h10
`define FLP_OFS_AREA 8'h14
`define FLP_OFS_ECCTM 8'h18
`define FLP_OFS_DMYECC 8'h1C
`define FLP_OFS_LKSTAT 8'h20
`define FLP_OFS_AUTH 8'h24
`define FLP_OFS_OTP0 8'h28
`define FLP_OFS_OTP1 8'h2C
`define FLP_OFS_OTP2 8'h30
`define FLP_OFS_CFGID 8'h34
`define FLP_OFS_LOCKS0 8'h38
`define FLP_OFS_LOCKS1 8'h3C
`define FLP_OFS_LOCKS2 8'h40
`define FLP_OFS_FAULT 8'h44
// Command codes
`define FLP_CMD_LOCKPRG 8'h77
`define FLP_CMD_LOCKRD 8'h71
`define FLP_CMD_OTPSET 8'h5A
`define FLP_CMD_PROG 8'hE8
`define FLP_CMD_ERASE 8'h20
`define FLP_CMD_CFGSET 8'h40
`define FLP_CMD_CLEAR 8'h50
`define FLP_CMD_STOP 8'hB3
`define FLP_CMD_FINAL 8'hD0
// Mode entry values
`define FLP_ENTRY_READ 16'h0000
`define FLP_ENTRY_DATA 16'h0080
`define FLP_ENTRY_CODE 16'h0001
// OTP set data addresses
`define FLP_OTP_ADDR_LO 32'hFF380040
`define FLP_OTP_ADDR_HI 32'hFF380060
`define FLP_OTP_ADDR_UB 32'hFF380090
`define FLP_OTP_HI_LSB 6
// Block mapping: 8 small blocks of 8 KB then 32 KB blocks
`define FLP_SMALL_SHIFT 13
`define FLP_LARGE_SHIFT 15
`define FLP_SMALL_CNT 8
// Status bit positions
`define FLP_ST_READY 0
`define FLP_ST_ILGL 1
`define FLP_ST_CMDLK 2
`define FLP_ST_CODE_AREA_ACCESS_ERROR 3
`define FLP_ST_DATA_AREA_ACCESS_ERROR 4
`define FLP_ST_ECC_BUFFER_FULL 5
`define FLP_ST_SECLK 6
`define FLP_ST_VECBLK 7
// Processing time of a command in cycles
`define FLP_BUSY_CYC 4'h8
`endif

/* src/flp_pkg.sv */
// Types shared by the flash lock and OTP protection block
package flp_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } flp_bus_s;
    typedef enum logic [3:0] {
        FLP_IDLE = 4'b0001,
        FLP_WAIT_D0 = 4'b0010,
        FLP_BUSY = 4'b0100,
        FLP_DONE = 4'b1000
    } flp_state_e;
endpackage : flp_pkg

/* src/flp_prot.sv */
// Flash sequencer lock bit, OTP and command protection logic
// Summary of operation
// - Area select 1 maps setting data into user-area reads for checking.
// - Stored ID readable only after self authentication succeeds.
// - Lock program is 77 then D0 at block start; erase clears lock.
// - Lock read is 71 then D0; result lands in lock status bit.
// - OTP set uses start address as data address; starts on D0.
// - One OTP flag per block, 70 flags: eight 8 KB, 61 of 32 KB at flags 9 to 69.
// - Writing 0 sets a block OTP; only reset returns a flag to 1.
// - OTP data layout at FF380040, FF380060 bit 6, FF380090 bit 0.
// - ECC disable bit makes programming store dummy ECC and parity.
// - Dummy ECC write while buffer full waits; write when flag is 0. Here a write always overwrites dmyecc_r at once.
// - Security locked: code-mode command or data-mode config locks.
// - Entering code mode without released security locks commands.
// - Lock gained while security unreleased survives forced stop.
// - Data mode accepts ordinary commands regardless of security.
// - Program, erase or lock program to OTP block locks commands.
// - After any OTP set, config set of reset vector is refused.
// - Entry 0000 is read mode; any command but clear or stop locks there.
// - Protect bit 0 refuses writes to lock-bit-0 blocks; 1 lifts it.
// - Command while locked sets illegal error, others kept.
// - Clear lock by status clear when ready or stop, no access errors.
`timescale 1ns/1ps
`include "flp_params.svh"
module flp_prot #(
    parameter int NBLK = 70, // User-area blocks
    parameter int NHI = 64 // Upper OTP flags
) (
    input wire logic clock_i, // 20 MHz clock
    input wire logic reset_i, // Sync reset, high
    input wire flp_pkg::flp_bus_s bus_i, // Register port
    input wire logic self_auth_ok_i, // ID authentication passed
    input wire logic [31:0] user_rdata_i, // Normal user-area data
    output logic [31:0] rdata_o, // Read data, one cycle later
    output logic [31:0] user_rdata_o, // User read after area mux
    output logic cmd_locked_o, // Command-locked flag
    output logic [6:0] ecc_dummy_o, // Dummy ECC to the array
    output logic ecc_inject_o // Programming uses dummy ECC
);
    import flp_pkg::*;

    flp_state_e state_r, state_nxt;
    logic [7:0] first_r;
    logic [31:0] saddr_r;
    logic [15:0] entry_r;
    logic prot_dis_r, area_sel_r, ecc_dis_r, ecc_buffer_full_r;
    logic [6:0] dmyecc_r;
    logic lock_rd_r;
    logic [NBLK-1:0] otp_r, lockbit_r;
    logic [NHI-1:0] otp_hi_r;
    logic otp_ub_r, vec_blk_r;
    logic cmdlk_r, ilgl_r, sticky_r, code_area_access_error_r, data_area_access_error_r;
    logic [3:0] busy_r;
    logic [31:0] rdata_r, cfg_id_r;

    // Address decode of each register strobe
    wire wr = bus_i.wr;
    wire w_cmd = wr && bus_i.addr == `FLP_OFS_CMD;
    wire w_sadr = wr && bus_i.addr == `FLP_OFS_SADDR;
    wire w_ent = wr && bus_i.addr == `FLP_OFS_ENTRY;
    wire w_prot = wr && bus_i.addr == `FLP_OFS_PROT;
    wire w_area = wr && bus_i.addr == `FLP_OFS_AREA;
    wire w_ectm = wr && bus_i.addr == `FLP_OFS_ECCTM;
    wire w_decc = wr && bus_i.addr == `FLP_OFS_DMYECC;
    wire w_cfid = wr && bus_i.addr == `FLP_OFS_CFGID;
    wire w_flt = wr && bus_i.addr == `FLP_OFS_FAULT;
    wire [7:0] code = bus_i.wdata[7:0];
    wire ready = (state_r == FLP_IDLE) || (state_r == FLP_DONE);

    // Mode decode
    wire read_mode = entry_r == `FLP_ENTRY_READ;
    wire code_mode = entry_r == `FLP_ENTRY_CODE;
    wire data_mode = entry_r == `FLP_ENTRY_DATA;
    wire sec_lock = !self_auth_ok_i;

    // Block index of the start address, small then large blocks
    wire [31:0] small_ix = saddr_r >> `FLP_SMALL_SHIFT;
    wire [31:0] large_ix = (saddr_r >> `FLP_LARGE_SHIFT) + 32'h7;
    wire [31:0] blk_full = (small_ix < 32'h8) ? small_ix : large_ix;
    wire blk_ok = blk_full < NBLK;
    wire [6:0] blk = blk_ok ? blk_full[6:0] : 7'h0;
    wire otp_hit = blk_ok && !otp_r[blk];
    wire lock_hit = blk_ok && !lockbit_r[blk] && !prot_dis_r;

    // Final D0 step of a two-write command
    wire is_final = w_cmd && state_r == FLP_WAIT_D0;
    wire bad_final = is_final && code != `FLP_CMD_FINAL;
    wire writes_blk = first_r == `FLP_CMD_PROG ||
        first_r == `FLP_CMD_ERASE || first_r == `FLP_CMD_LOCKPRG;
    wire cfg_cmd = first_r == `FLP_CMD_CFGSET || first_r == `FLP_CMD_OTPSET;
    wire sec_viol = sec_lock && (code_mode || (data_mode && cfg_cmd));
    wire vec_viol = first_r == `FLP_CMD_CFGSET && vec_blk_r;
    wire blk_viol = writes_blk && (otp_hit || lock_hit);
    wire final_viol = bad_final || (is_final &&
        (sec_viol || vec_viol || blk_viol || read_mode));

    // Immediate commands and first-write checks
    wire is_clear = w_cmd && code == `FLP_CMD_CLEAR && state_r != FLP_WAIT_D0;
    wire is_stop = w_cmd && code == `FLP_CMD_STOP;
    wire is_first = w_cmd && !is_clear && !is_stop &&
        state_r != FLP_WAIT_D0;
    wire no_acc_err = !code_area_access_error_r && !data_area_access_error_r;
    // Clear allowed only when ready; stop any time; sticky blocks stop
    wire do_unlock = no_acc_err && ((is_clear && ready) ||
        (is_stop && !sticky_r));
    wire first_known = code == `FLP_CMD_LOCKPRG || code == `FLP_CMD_LOCKRD
        || code == `FLP_CMD_OTPSET || code == `FLP_CMD_PROG
        || code == `FLP_CMD_ERASE || code == `FLP_CMD_CFGSET;
    wire first_viol = is_first && (read_mode || !first_known ||
        (cmdlk_r) || state_r == FLP_BUSY);
    wire enter_code = w_ent && bus_i.wdata[15:0] == `FLP_ENTRY_CODE &&
        sec_lock;
    wire go_lock = first_viol || final_viol || enter_code ||
        (is_final && cmdlk_r);
    wire cmd_in_lock = cmdlk_r && (is_first || is_final);

    // Command sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            FLP_IDLE, FLP_DONE: begin
                if (is_first && !first_viol) begin
                    state_nxt = FLP_WAIT_D0;
                end
            end
            FLP_WAIT_D0: begin
                if (is_stop) begin
                    state_nxt = FLP_IDLE;
                end else if (is_final) begin
                    state_nxt = final_viol || cmdlk_r ? FLP_IDLE : FLP_BUSY;
                end
            end
            FLP_BUSY: begin
                if (is_stop) begin
                    state_nxt = FLP_IDLE;
                end else if (busy_r == 4'h0) begin
                    state_nxt = FLP_DONE;
                end
            end
            default: state_nxt = FLP_IDLE;
        endcase
    end

    // Sequencer state and busy counter
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_r <= FLP_IDLE;
            first_r <= 8'h00;
            busy_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (is_first) begin
                first_r <= code;
            end
            if (state_nxt == FLP_BUSY && state_r != FLP_BUSY) begin
                busy_r <= `FLP_BUSY_CYC;
            end else if (busy_r != 4'h0) begin
                busy_r <= busy_r - 4'h1;
            end
        end
    end

    // Command execution once processing finishes
    wire finish = state_r == FLP_BUSY && busy_r == 4'h0 && !is_stop;
    wire otp_lo_sel = saddr_r == `FLP_OTP_ADDR_LO;
    wire otp_hi_sel = saddr_r == `FLP_OTP_ADDR_HI;
    wire otp_ub_sel = saddr_r == `FLP_OTP_ADDR_UB;
    wire [NBLK-1:0] otp_wdata;
    wire [NHI-1:0] otp_hdata;
    assign otp_wdata = {cfg_id_r[NBLK-65:0], cfg_id_r, cfg_id_r};
    assign otp_hdata = {cfg_id_r, cfg_id_r};

    // Flags, OTP store and lock bits
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            otp_r <= '1;
            otp_hi_r <= '1;
            otp_ub_r <= 1'b1;
            lockbit_r <= '1;
            lock_rd_r <= 1'b1;
            vec_blk_r <= 1'b0;
        end else if (finish) begin
            case (first_r)
                `FLP_CMD_LOCKPRG: lockbit_r[blk] <= 1'b0;
                `FLP_CMD_ERASE: lockbit_r[blk] <= 1'b1;
                `FLP_CMD_LOCKRD: lock_rd_r <= lockbit_r[blk];
                `FLP_CMD_OTPSET: begin
                    // Zeros only accumulate, so a flag cannot return to 1
                    if (otp_lo_sel) begin
                        otp_r <= otp_r & otp_wdata;
                    end
                    if (otp_hi_sel) begin
                        otp_hi_r <= otp_hi_r & otp_hdata;
                    end
                    if (otp_ub_sel) begin
                        otp_ub_r <= otp_ub_r & cfg_id_r[0];
                    end
                    vec_blk_r <= 1'b1;
                end
                default: vec_blk_r <= vec_blk_r;
            endcase
        end
    end

    // Command lock, error flags, control registers
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cmdlk_r <= 1'b0;
            ilgl_r <= 1'b0;
            sticky_r <= 1'b0;
            code_area_access_error_r <= 1'b0;
            data_area_access_error_r <= 1'b0;
            saddr_r <= 32'h0;
            entry_r <= `FLP_ENTRY_READ;
            prot_dis_r <= 1'b0;
            area_sel_r <= 1'b0;
            ecc_dis_r <= 1'b0;
            dmyecc_r <= 7'h7F;
            ecc_buffer_full_r <= 1'b0;
            cfg_id_r <= 32'hFFFFFFFF;
        end else begin
            // A new lock wins over a same-cycle clear
            if (go_lock || cmd_in_lock) begin
                cmdlk_r <= 1'b1;
                ilgl_r <= 1'b1;
                if (sec_lock) begin
                    sticky_r <= 1'b1;
                end
            end else if (do_unlock) begin
                cmdlk_r <= 1'b0;
                ilgl_r <= 1'b0;
                sticky_r <= 1'b0;
            end
            if (w_flt) begin
                code_area_access_error_r <= bus_i.wdata[0];
                data_area_access_error_r <= bus_i.wdata[1];
            end
            if (w_sadr) begin
                saddr_r <= bus_i.wdata;
            end
            if (w_ent) begin
                entry_r <= bus_i.wdata[15:0];
            end
            if (w_prot) begin
                prot_dis_r <= bus_i.wdata[0];
            end
            if (w_area) begin
                area_sel_r <= bus_i.wdata[0];
            end
            if (w_ectm) begin
                ecc_dis_r <= bus_i.wdata[0];
            end
            // Buffer holds one dummy word until a command finishes or a forced stop
            if (w_decc) begin
                dmyecc_r <= bus_i.wdata[6:0];
                ecc_buffer_full_r <= 1'b1;
            end else if (finish || is_stop) begin
                ecc_buffer_full_r <= 1'b0;
            end
            if (w_cfid) begin
                cfg_id_r <= bus_i.wdata;
            end
        end
    end

    // Setting-area view: OTP words then stored ID after authentication
    wire [31:0] set_view = otp_lo_sel ? otp_r[31:0] :
        otp_hi_sel ? {otp_hi_r[25:0], 6'h3F} :
        otp_ub_sel ? {31'h7FFFFFFF, otp_ub_r} :
        self_auth_ok_i ? cfg_id_r : 32'h0;
    assign user_rdata_o = area_sel_r ? set_view : user_rdata_i;
    assign cmd_locked_o = cmdlk_r;
    assign ecc_dummy_o = dmyecc_r;
    assign ecc_inject_o = ecc_dis_r;

    // Read data mux
    wire [31:0] status_w = {24'h0, vec_blk_r, sec_lock, ecc_buffer_full_r, data_area_access_error_r,
        code_area_access_error_r, cmdlk_r, ilgl_r, ready};
    wire [31:0] rd_mux =
        bus_i.addr == `FLP_OFS_SADDR ? saddr_r :
        bus_i.addr == `FLP_OFS_STATUS ? status_w :
        bus_i.addr == `FLP_OFS_ENTRY ? {16'h0, entry_r} :
        bus_i.addr == `FLP_OFS_PROT ? {31'h0, prot_dis_r} :
        bus_i.addr == `FLP_OFS_AREA ? {31'h0, area_sel_r} :
        bus_i.addr == `FLP_OFS_ECCTM ? {31'h0, ecc_dis_r} :
        bus_i.addr == `FLP_OFS_DMYECC ? {25'h0, dmyecc_r} :
        bus_i.addr == `FLP_OFS_LKSTAT ? {31'h0, lock_rd_r} :
        bus_i.addr == `FLP_OFS_AUTH ? {31'h0, sec_lock} :
        bus_i.addr == `FLP_OFS_OTP0 ? otp_r[31:0] :
        bus_i.addr == `FLP_OFS_OTP1 ? otp_r[63:32] :
        bus_i.addr == `FLP_OFS_OTP2 ? {26'h3FFFFFF, otp_r[NBLK-1:64]} :
        bus_i.addr == `FLP_OFS_CFGID ? (self_auth_ok_i ? cfg_id_r : 32'h0) :
        bus_i.addr == `FLP_OFS_LOCKS0 ? lockbit_r[31:0] :
        bus_i.addr == `FLP_OFS_LOCKS1 ? lockbit_r[63:32] :
        bus_i.addr == `FLP_OFS_LOCKS2 ? {26'h0, lockbit_r[NBLK-1:64]} :
        bus_i.addr == `FLP_OFS_FAULT ? {30'h0, data_area_access_error_r, code_area_access_error_r} : 32'h0;

    // Read data registered; unmapped and command area read as zero
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= bus_i.rd ? rd_mux : 32'h0;
        end
    end
    assign rdata_o = rdata_r;
endmodule : flp_prot

/* testbench/flp_prot_checker.sv */
// Concurrent checks on the ports of the flash protection block
`timescale 1ns/1ps
`include "flp_params.svh"
module flp_prot_checker #(
    parameter int NBLK = 70, // User-area blocks
    parameter int NHI = 64 // Upper OTP flags
) (
    input wire logic clock_i, // Clock
    input wire logic reset_i, // Sync reset
    input wire flp_pkg::flp_bus_s bus_i, // Register port
    input wire logic self_auth_ok_i, // Security released
    input wire logic [31:0] user_rdata_i, // Raw user data
    input wire logic [31:0] user_rdata_o, // Area mux output
    input wire logic cmd_locked_o, // Lock flag
    input wire logic [6:0] ecc_dummy_o, // Dummy ECC
    input wire logic ecc_inject_o // ECC disable
);
    import flp_pkg::*;
    logic sel_r; // Area select mirror
    logic [15:0] entry_r; // Mode entry mirror
    logic [3:0] since_r; // Cycles since a command write
    wire wr_cmd = bus_i.wr && bus_i.addr == `FLP_OFS_CMD;
    wire wr_ecc = bus_i.wr && bus_i.addr == `FLP_OFS_DMYECC;
    wire wr_ent = bus_i.wr && bus_i.addr == `FLP_OFS_ENTRY;
    wire wr_area = bus_i.wr && bus_i.addr == `FLP_OFS_AREA;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    // Mirrors, so mode-dependent checks know the state
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sel_r <= 1'b0;
            entry_r <= 16'h0000;
            // Reset also drops the lock, so it counts as a clearing event
            since_r <= 4'h0;
        end else begin
            if (wr_area) sel_r <= bus_i.wdata[0];
            if (wr_ent) entry_r <= bus_i.wdata[15:0];
            since_r <= wr_cmd ? 4'h0 : (&since_r ? 4'hF : since_r + 4'h1);
        end
    end
    a_reset_values: assert property (disable iff (1'b0)
        reset_i |=> !cmd_locked_o && ecc_dummy_o == 7'h7F && !ecc_inject_o)
        else $error("outputs not at reset values");
    a_area_pass: assert property (!sel_r |->
        user_rdata_o == user_rdata_i) else $error("user data altered");
    // A lock only goes away shortly after a command write
    a_lock_hold: assert property ($fell(cmd_locked_o) |->
        since_r < 4'hC) else $error("lock dropped without command");
    a_read_lock: assert property (wr_cmd && entry_r == 16'h0000 &&
        !(bus_i.wdata[7:0] inside {`FLP_CMD_CLEAR, `FLP_CMD_STOP})
        |-> ##[1:3] cmd_locked_o) else $error("read mode command not locked");
    a_code_entry: assert property (wr_ent && !self_auth_ok_i &&
        bus_i.wdata[15:0] == `FLP_ENTRY_CODE |-> ##[1:3] cmd_locked_o)
        else $error("code mode entry not locked");
    a_ecc_dummy: assert property (wr_ecc |=>
        ecc_dummy_o == $past(bus_i.wdata[6:0])) else $error("dummy ECC bad");
    a_ecc_steady: assert property (!wr_ecc |=>
        $stable(ecc_dummy_o)) else $error("dummy ECC changed");
    a_inject_bit: assert property (bus_i.wr &&
        bus_i.addr == `FLP_OFS_ECCTM |=> ecc_inject_o == $past(bus_i.wdata[0]))
        else $error("ECC disable bit bad");
endmodule : flp_prot_checker
bind flp_prot flp_prot_checker #(.NBLK(NBLK), .NHI(NHI)) u_chk (
    .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i),
    .self_auth_ok_i(self_auth_ok_i), .user_rdata_i(user_rdata_i),
    .user_rdata_o(user_rdata_o), .cmd_locked_o(cmd_locked_o),
    .ecc_dummy_o(ecc_dummy_o), .ecc_inject_o(ecc_inject_o));

/* testbench/flp_host.sv */
// Host-side register master that issues flash commands
`timescale 1ns/1ps
module flp_host (
    input wire logic clock_i, // Bus clock
    input wire logic [31:0] rdata_i, // Read data from block
    output flp_pkg::flp_bus_s bus_o // Register port
);
    import flp_pkg::*;
    initial bus_o = '0;
    // One-cycle strobe; idle cycle after avoids double assignment
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_o.addr <= a;
        bus_o.wdata <= d;
        bus_o.wr <= 1'b1;
        @(posedge clock_i);
        bus_o.wr <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_o.addr <= a;
        bus_o.rd <= 1'b1;
        @(posedge clock_i);
        bus_o.rd <= 1'b0;
        #1 d = rdata_i;
        @(posedge clock_i);
    endtask : rd
    // Code first, final write always D0
    task automatic cmd2(input logic [7:0] c);
        wr(8'h00, {24'h0, c});
        wr(8'h00, 32'h0000_00D0);
    endtask : cmd2
endmodule : flp_host

/* testbench/test_flp_prot.sv */
// Self-checking bench for the flash lock and OTP protection block
`timescale 1ns/1ps
`include "flp_params.svh"
module test_flp_prot;
    import flp_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic self_auth_ok_i = 1'b0;
    logic [31:0] user_rdata_i = 32'h0;
    flp_bus_s bus_i;
    logic [31:0] rdata_o, user_rdata_o, v;
    logic cmd_locked_o, ecc_inject_o;
    logic [6:0] ecc_dummy_o;
    logic [31:0] seed = 32'h36;
    int bad_count = 0, compares = 0, cycles = 0;
    int m_lock = 0, m_lk = 1, m_otp = 1, m_prot = 0, m_entry = 0, m_sa = 0;
    always #25 clock_i = ~clock_i;
    flp_prot dut (.clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i),
        .self_auth_ok_i(self_auth_ok_i), .user_rdata_i(user_rdata_i),
        .rdata_o(rdata_o), .user_rdata_o(user_rdata_o),
        .cmd_locked_o(cmd_locked_o), .ecc_dummy_o(ecc_dummy_o),
        .ecc_inject_o(ecc_inject_o));
    flp_host host (.clock_i(clock_i), .rdata_i(rdata_o), .bus_o(bus_i));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Bounded poll of the ready flag
    task automatic wait_ready();
        logic [31:0] s;
        repeat (2) @(posedge clock_i);
        for (int i = 0; i < 40; i++) begin
            host.rd(`FLP_OFS_STATUS, s);
            if (s[`FLP_ST_READY] === 1'b1) return;
        end
        chk("sequencer_ready_flag", 1, 0);
    endtask : wait_ready
    // Command through the host, model decides the lock outcome
    task automatic run(input logic [7:0] c);
        logic [31:0] s;
        int was;
        was = m_lock;
        host.cmd2(c);
        if (m_lock || m_entry == 0 || (m_entry == 1 && !self_auth_ok_i) ||
            (c == `FLP_CMD_CFGSET && !self_auth_ok_i) ||
            (c inside {8'h77, `FLP_CMD_PROG, `FLP_CMD_ERASE} &&
            ((m_sa == 0 && !m_otp) || (m_sa == 'h2000 && !m_prot && !m_lk))))
            m_lock = 1;
        else if (c == 8'h77) m_lk = 0;
        else if (c == `FLP_CMD_ERASE) m_lk = 1;
        wait_ready();
        chk("cmd_locked_o", m_lock, cmd_locked_o);
        if (was) begin
            host.rd(`FLP_OFS_STATUS, s);
            chk("illegal_cmd_error", 1, s[`FLP_ST_ILGL]);
        end
    endtask : run
    task automatic unlock(input logic [7:0] c, input int e);
        host.wr(`FLP_OFS_CMD, {24'h0, c});
        wait_ready();
        m_lock = e;
        chk("cmd_locked_o", m_lock, cmd_locked_o);
    endtask : unlock
    task automatic lkrd();
        run(8'h71);
        host.rd(`FLP_OFS_LKSTAT, v);
        chk("lock_read_result", m_lk, v[0]);
    endtask : lkrd
    // Hang guard, well above the expected run length
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        chk("cmd_locked_o", 0, cmd_locked_o);
        chk("ecc_dummy_o", 7'h7F, ecc_dummy_o);
        for (int i = 0; i < 4; i++) begin
            user_rdata_i <= xs();
            @(posedge clock_i);
            #1 chk("user_rdata_o", user_rdata_i, user_rdata_o);
        end
        host.wr(`FLP_OFS_ECCTM, 32'h1);
        chk("ecc_inject_o", 1, ecc_inject_o);
        for (int i = 0; i < 4; i++) begin
            host.rd(`FLP_OFS_STATUS, v);
            chk("ecc_buffer_full", 0, v[`FLP_ST_ECC_BUFFER_FULL]);
            v = xs();
            host.wr(`FLP_OFS_DMYECC, v);
            chk("ecc_dummy_o", v[6:0], ecc_dummy_o);
            host.rd(`FLP_OFS_STATUS, v);
            chk("ecc_buffer_full", 1, v[`FLP_ST_ECC_BUFFER_FULL]);
            // Forced stop drains the buffer so the next write sees it empty
            host.wr(`FLP_OFS_CMD, {24'h0, `FLP_CMD_STOP});
        end
        host.wr(`FLP_OFS_ECCTM, 32'h0);
        // Read mode: lock, illegal while locked, forced stop
        self_auth_ok_i <= 1'b1;
        run(8'h77);
        run(`FLP_CMD_PROG);
        // An access error keeps the lock even through a forced stop
        host.wr(`FLP_OFS_FAULT, 32'h1);
        unlock(`FLP_CMD_STOP, 1);
        host.wr(`FLP_OFS_FAULT, 32'h0);
        unlock(`FLP_CMD_STOP, 0);
        // Data mode with security locked again
        self_auth_ok_i <= 1'b0;
        host.wr(`FLP_OFS_ENTRY, {16'h0, `FLP_ENTRY_DATA});
        m_entry = 'h80;
        host.wr(`FLP_OFS_SADDR, 32'h2000);
        m_sa = 'h2000;
        lkrd();
        run(8'h77);
        lkrd();
        run(`FLP_CMD_PROG);
        unlock(`FLP_CMD_CLEAR, 0);
        host.wr(`FLP_OFS_PROT, 32'h1);
        m_prot = 1;
        run(`FLP_CMD_PROG);
        run(`FLP_CMD_ERASE);
        lkrd();
        // OTP flag 0 set, then a try to undo it
        self_auth_ok_i <= 1'b1;
        host.wr(`FLP_OFS_SADDR, `FLP_OTP_ADDR_LO);
        m_sa = 1;
        for (int i = 0; i < 2; i++) begin
            host.wr(`FLP_OFS_CFGID, i ? 32'hFFFFFFFF : 32'hFFFFFFFE);
            run(`FLP_CMD_OTPSET);
            host.rd(`FLP_OFS_OTP0, v);
            chk("block_otp_flag", 32'h2, v[1:0]);
        end
        m_otp = 0;
        // Setting view of the OTP word, then the stored ID after auth
        host.wr(`FLP_OFS_AREA, 32'h1);
        chk("user_rdata_o", 32'hFFFFFFFE, user_rdata_o);
        host.wr(`FLP_OFS_AREA, 32'h0);
        host.rd(`FLP_OFS_CFGID, v);
        chk("cfg_id_read", 32'hFFFFFFFF, v);
        host.rd(`FLP_OFS_STATUS, v);
        chk("vector_blocked", 1, v[`FLP_ST_VECBLK]);
        host.wr(`FLP_OFS_SADDR, 32'h0);
        m_sa = 0;
        run(`FLP_CMD_ERASE);
        unlock(`FLP_CMD_STOP, 0);
        self_auth_ok_i <= 1'b0;
        host.rd(`FLP_OFS_CFGID, v);
        chk("cfg_id_read", 32'h0, v);
        run(`FLP_CMD_CFGSET);
        unlock(`FLP_CMD_STOP, 1);
        // Second reset, then code mode entry without authentication
        reset_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        host.wr(`FLP_OFS_ENTRY, {16'h0, `FLP_ENTRY_CODE});
        repeat (2) @(posedge clock_i);
        chk("cmd_locked_o", 1, cmd_locked_o);
        final_report();
    end
endmodule : test_flp_prot
